//--- rtl/ref_switch_pkg.sv
// Package: register map, field layout and encodings for reference switching
package ref_switch_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFFSET    = 8'h00; // Mode, holdover, force
    localparam logic [7:0] INPUT_OFFSET   = 8'h04; // Enables, pre-dividers
    localparam logic [7:0] PIN_OFFSET     = 8'h08; // Select pin directions
    localparam logic [7:0] STATUS_OFFSET  = 8'h0C; // Active input, holdover

    // Control register fields
    localparam int MODE_LSB          = 0;  // 3-bit input_select_mode
    localparam int HOLD_EN_BIT       = 4;  // Holdover enable
    localparam int FORCE_HOLD_BIT    = 5;  // Holdover force
    localparam int LOSS_DIS_BIT      = 6;  // lock_loss_detect_disable
    localparam int LD_MUX_LSB        = 8;  // 2-bit lock status pin source

    // Input register fields
    localparam int INPUT_EN_LSB      = 0;  // 3-bit input_enable
    localparam int PREDIV_LSB        = 4;  // 3 x 2-bit pre-divider codes

    // Pin register fields (1 = pin is input)
    localparam int PIN0_DIR_BIT      = 0;
    localparam int PIN1_DIR_BIT      = 1;

    // Reset values
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
    localparam logic [31:0] INPUT_RESET = 32'h0000_0007;
    localparam logic [31:0] PIN_RESET   = 32'h0000_0000;

    // Input selection modes
    localparam logic [2:0] MODE_MAN0 = 3'h0;
    localparam logic [2:0] MODE_MAN1 = 3'h1;
    localparam logic [2:0] MODE_MAN2 = 3'h2;
    localparam logic [2:0] MODE_PIN  = 3'h3;
    localparam logic [2:0] MODE_AUTO = 3'h4;

    // Lock status pin sources
    localparam logic [1:0] LD_RAIL  = 2'h0;
    localparam logic [1:0] LD_LOOP1 = 2'h1;
    localparam logic [1:0] LD_BOTH  = 2'h2;
    localparam logic [1:0] LD_HOLD  = 2'h3;

    // AHB transfer type
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // Holdover state machine, Gray along idle -> hold -> idle
    typedef enum logic [1:0] {
        ST_RUN  = 2'b00,
        ST_HOLD = 2'b01
    } hold_state_t;

    // Synchronised inputs travelling together
    typedef struct packed {
        logic pin1;
        logic pin0;
        logic lock1;
    } sync_bits_t;

endpackage

//--- rtl/ref_switch.sv
// Reference input switching logic with AHB-Lite register slave
// How it works
// - Modes 0..2 pin active reference fixed
// - Manual selection runs input despite enable
// - Manual holdover on lock loss unless disabled
// - Manual holdover exit judged on selected input
// - Mode 3 picks reference from select pins
// - Any input-direction select pin change raises switch event
// - Output-direction select pin reads as zero
// - Pins 00,01,10 pick input; 11 holdover
// - Pin mode runs selected input despite enable
// - Lock status pin routes rail or locks
// - No holdover: switch reference at once
// - Holdover: hold, then complete pin switch
// - Mode 4 steps to next enabled input
// - Automatic stepping skips disabled inputs
// - Automatic entry keeps reference if locked
// - Automatic: lock drop raises switch event
// - Lock must return before next lock event
// - Each input has pre-divider 1,2,4,8
// - Holdover exits on frequency match or disable
// - Force bit holds regardless of state
//
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module ref_switch
(
    // Clock, reset and the freeze control
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        clk_en,
    // AHB-Lite slave side, zero wait states
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Far side: select pins and loop status, all levels
    input  wire logic        select_pin_0,
    input  wire logic        select_pin_1,
    input  wire logic        loop1_lock_detect,
    input  wire logic        loop2_lock_detect,
    input  wire logic        dac_rail,
    input  wire logic        freq_in_tolerance,
    // Selection results toward the input buffers and the loop
    output logic      [2:0]  buffer_run,
    output logic      [1:0]  active_ref,
    output logic             holdover,
    output logic      [5:0]  prediv_sel,
    output logic             lock_status_pin
);
    import ref_switch_pkg::*;

    // Overview
    // Three reference inputs feed the first loop; this block decides
    // which one is active and when the loop coasts in holdover.
    // Manual modes name the input directly. Pin mode follows two
    // select pins, each gated by its direction bit. Automatic mode
    // steps through the enabled inputs in order 0, 1, 2 whenever the
    // first loop loses lock, and needs lock back before stepping again.
    // Holdover is left when the tolerance flag reports a match on the
    // active input, or when the host clears the holdover enable.
    // Limitation: the tolerance comparison itself lives outside; this
    // block only trusts the flag it is given on this clock.
    // Trade-off: pin and lock edges cost three cycles of latency, in
    // return for exactly one event per level change.
    // Reset state: input 0 active, all buffers running, no holdover.
    // Every output is a flop or a constant, never a decode of inputs.

    // Register map, byte offsets
    //   0x00 control: mode 2:0, hold enable 4, force 5,
    //        lock-loss disable 6, lock pin source 9:8
    //   0x04 inputs: enables 2:0, pre-divider codes 9:4
    //   0x08 pins: direction of select pins 1:0, 1 = input
    //   0x0C status: active input 1:0, holdover 3, lock 4
    // Writes land one cycle after their address phase is taken.

    // Pre-divider code: 0=1, 1=2, 2=4, 3=8 per input
    // The loop reference divider stays put across a switch; the
    // per-input code absorbs the frequency difference instead.
    // Next enabled input after cur in order 0,1,2, wrapping
    // If no other input is enabled the current one is kept, so
    // a lone enabled input never leaves the loop without a source.
    function automatic logic [1:0] next_enabled(input logic [1:0] cur,
                                                input logic [2:0] en);
        logic [1:0] cand;
        logic [1:0] res;
        cand = cur;
        res  = cur;
        // Walk from the input after cur; first enabled one wins
        for (int i = 0; i < 3; i++) begin
            cand = (cand == 2'd2) ? 2'd0 : 2'(cand + 2'd1);
            if (en[cand] && res == cur) begin
                res = cand;
            end
        end
        return res;
    endfunction

    // Register storage
    // Only bits with a meaning are kept; the rest read back as zero
    logic [31:0] ctrl_reg, ctrl_next;     // Mode and holdover control
    logic [31:0] input_reg, input_next;   // Enables and pre-dividers
    logic [31:0] pin_reg, pin_next;       // Pin directions

    // Bus data-phase capture
    // Address phase is latched so a write can land a cycle later
    logic        wr_pend_reg, wr_pend_next;   // Write pending
    logic [7:0]  addr_reg, addr_next;         // Latched offset
    logic [31:0] rdata_reg, rdata_next;       // Read data

    // Synchronisers: first stage only feeds second
    // The third stage is history for edge detection; it reads the
    // settled second stage, never the possibly metastable first.
    sync_bits_t  s1_reg, s2_reg, s3_reg;      // Two stages plus history

    // Selection state
    // Reset picks input 0 with every buffer running, as mode 0 does
    logic [1:0]  active_reg, active_next;     // Active reference
    hold_state_t st_reg, st_next;             // Holdover state
    logic [2:0]  prev_mode_reg, prev_mode_next; // Mode last cycle
    logic        armed_reg, armed_next;       // Lock-loss event armed
    logic [2:0]  run_reg, run_next;           // Buffer runs
    logic        ld_reg, ld_next;             // Lock status pin

    // Decoded fields
    // Plain views of register bits and synchronised levels
    logic [2:0]  mode;
    logic        hold_en, force_hold, loss_dis;
    logic [1:0]  ld_mux;
    logic [2:0]  in_en;
    logic        pin0_v, pin1_v;
    logic        pin_chg, lock_fall, bus_go;

    // Field decode and edge detection from flops; bus_go straight from bus inputs
    always_comb begin
        mode       = ctrl_reg[MODE_LSB +: 3];
        hold_en    = ctrl_reg[HOLD_EN_BIT];
        force_hold = ctrl_reg[FORCE_HOLD_BIT];
        loss_dis   = ctrl_reg[LOSS_DIS_BIT];
        ld_mux     = ctrl_reg[LD_MUX_LSB +: 2];
        in_en      = input_reg[INPUT_EN_LSB +: 3];
        // Output-direction pins read as zero
        pin0_v     = s2_reg.pin0 & pin_reg[PIN0_DIR_BIT];
        pin1_v     = s2_reg.pin1 & pin_reg[PIN1_DIR_BIT];
        // Edges judged on synchronised stages only
        pin_chg    = (pin0_v != (s3_reg.pin0 & pin_reg[PIN0_DIR_BIT]))
                   | (pin1_v != (s3_reg.pin1 & pin_reg[PIN1_DIR_BIT]));
        // Only a high-to-low step of the settled lock counts
        lock_fall  = s3_reg.lock1 & ~s2_reg.lock1;
        // NONSEQ or SEQ taken; IDLE and BUSY are ignored
        bus_go     = hsel & hready & htrans[1];
    end

    // Two-flop synchronisers for pins and lock detect
    // Pins and lock arrive from outside this clock; two flops keep
    // a late edge from splitting into two events downstream.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else if (clk_en) begin
            s1_reg <= '{pin1: select_pin_1, pin0: select_pin_0,
                        lock1: loop1_lock_detect};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Bus slave next state: zero wait, writes land in data phase
    // A read taken in the data phase of a write to the same register
    // sees the value being written, so back-to-back pairs agree.
    // Unmapped offsets read zero and swallow writes; size is not
    // decoded, every access is treated as a whole word.
    always_comb begin
        wr_pend_next = bus_go & hwrite;
        addr_next    = bus_go ? haddr[7:0] : addr_reg;
        ctrl_next    = ctrl_reg;
        input_next   = input_reg;
        pin_next     = pin_reg;
        rdata_next   = rdata_reg;
        // Data phase of a write: hwdata stands now
        if (wr_pend_reg) begin
            case (addr_reg)
                CTRL_OFFSET:  ctrl_next  = hwdata & 32'h0000_0377;
                INPUT_OFFSET: input_next = hwdata & 32'h0000_03F7;
                PIN_OFFSET:   pin_next   = hwdata & 32'h0000_0003;
                default:      ctrl_next  = ctrl_reg;
            endcase
        end
        // Address phase of a read: data stands in the next cycle
        if (bus_go && !hwrite) begin
            case (haddr[7:0])
                CTRL_OFFSET:   rdata_next = ctrl_next;
                INPUT_OFFSET:  rdata_next = input_next;
                PIN_OFFSET:    rdata_next = pin_next;
                // Status: lock bit 4, holdover bit 3, active input 1:0
                STATUS_OFFSET: rdata_next = {27'h0, s2_reg.lock1,
                                   st_reg == ST_HOLD, 1'b0, active_reg};
                default:       rdata_next = 32'h0000_0000;
            endcase
        end
    end

    // Bus slave registers
    // Register reset values come from the package constants
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            addr_reg    <= 8'h00;
            rdata_reg   <= 32'h0000_0000;
            ctrl_reg    <= CTRL_RESET;
            input_reg   <= INPUT_RESET;
            pin_reg     <= PIN_RESET;
        end else if (clk_en) begin
            wr_pend_reg <= wr_pend_next;
            addr_reg    <= addr_next;
            rdata_reg   <= rdata_next;
            ctrl_reg    <= ctrl_next;
            input_reg   <= input_next;
            pin_reg     <= pin_next;
        end
    end

    // Selection and holdover next state
    // Each mode first works out its next input and any holdover entry; the
    // holdover exit and the force bit are applied last so they win.
    always_comb begin
        logic       sw_evt;
        logic [1:0] target;
        logic       pin_hold;
        sw_evt         = 1'b0;
        target         = active_reg;
        pin_hold       = 1'b0;
        active_next    = active_reg;
        st_next        = st_reg;
        prev_mode_next = mode;
        armed_next     = armed_reg;
        run_next       = in_en;
        // Re-arm once lock returns
        if (s2_reg.lock1) begin
            armed_next = 1'b1;
        end
        case (mode)
            // Manual: the mode value is the input, no automatic switch
            MODE_MAN0, MODE_MAN1, MODE_MAN2: begin
                active_next = mode[1:0];
                // Holdover exit judged on this input
                run_next[mode[1:0]] = 1'b1;
                if (hold_en && lock_fall && !loss_dis) begin
                    st_next = ST_HOLD;
                end
            end
            // Pin select: the direction-gated pins name the input
            MODE_PIN: begin
                pin_hold = pin1_v & pin0_v;
                target   = {pin1_v, pin0_v & ~pin1_v};
                // Target codes 00->0, 01->1, 10->2; 11 is pin_hold
                if (!pin_hold) begin
                    run_next[target] = 1'b1;
                end
                // Lock loss only counts when host left it on
                sw_evt = pin_chg | (lock_fall & ~loss_dis);
                // Entering pin mode acts as a switch to the pin choice
                if (prev_mode_reg != MODE_PIN) begin
                    sw_evt = 1'b1;
                end
                if (pin_hold) begin
                    st_next = ST_HOLD;
                end else if (sw_evt && hold_en) begin
                    st_next = ST_HOLD;
                end else if (sw_evt || st_reg == ST_RUN) begin
                    active_next = target;
                end
            end
            // Automatic: step through enabled inputs on lock loss
            MODE_AUTO: begin
                // Entry keeps current input while locked
                // Unlocked entry steps at once, not waiting for a fall
                if (prev_mode_reg != MODE_AUTO && !s2_reg.lock1) begin
                    sw_evt = 1'b1;
                end
                // One event per loss; armed again once lock is back
                if (lock_fall && !loss_dis && armed_reg) begin
                    sw_evt     = 1'b1;
                    armed_next = 1'b0;
                end
                if (sw_evt) begin
                    active_next = next_enabled(active_reg, in_en);
                    if (hold_en) begin
                        st_next = ST_HOLD;
                    end
                end
            end
            // Reserved modes freeze the selection
            default: begin
                active_next = active_reg;
            end
        endcase
        // Holdover exit: match on active input or disable
        // The tolerance flag is judged on the active input, which in
        // pin mode is still the old one until this exit completes.
        // Pins at 11 keep the device in holdover whatever the flag.
        if (st_reg == ST_HOLD && !pin_hold &&
                (!hold_en || freq_in_tolerance)) begin
            st_next = ST_RUN;
            if (mode == MODE_PIN) begin
                active_next = target;
            end
        end
        // Force overrides every exit path
        if (force_hold) begin
            st_next = ST_HOLD;
        end
    end

    // Lock status pin source
    // Registered so the pin never glitches while the source changes.
    // Second loop lock is already on this clock and is used directly;
    // the holdover choice mirrors the state flop.
    always_comb begin
        case (ld_mux)
            LD_RAIL:  ld_next = dac_rail;
            LD_LOOP1: ld_next = s2_reg.lock1;
            LD_BOTH:  ld_next = s2_reg.lock1 & loop2_lock_detect;
            LD_HOLD:  ld_next = (st_reg == ST_HOLD);
            default:  ld_next = 1'b0;
        endcase
    end

    // Selection registers
    // Reset leaves input 0 active with all buffers running;
    // clk_en low holds every flop, the bus ones included
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active_reg    <= 2'h0;
            st_reg        <= ST_RUN;
            prev_mode_reg <= MODE_MAN0;
            armed_reg     <= 1'b0;
            run_reg       <= 3'h7;
            ld_reg        <= 1'b0;
        end else if (clk_en) begin
            active_reg    <= active_next;
            st_reg        <= st_next;
            prev_mode_reg <= prev_mode_next;
            armed_reg     <= armed_next;
            run_reg       <= run_next;
            ld_reg        <= ld_next;
        end
    end

    // Outputs straight from flops; response always OKAY
    // No wait states and no error response: every access completes
    // in one data phase, unmapped ones included.
    assign hrdata          = rdata_reg;
    assign hreadyout       = 1'b1;
    assign hresp           = 1'b0;
    assign buffer_run      = run_reg;
    assign active_ref      = active_reg;
    assign holdover        = (st_reg == ST_HOLD);
    assign prediv_sel      = input_reg[PREDIV_LSB +: 6];
    assign lock_status_pin = ld_reg;

endmodule

`default_nettype wire

//--- bench/ref_switch_monitor.sv
// Checker for reference selection, holdover and bus answers
`timescale 1ns/1ps
`default_nettype none
module ref_switch_monitor
    import ref_switch_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        select_pin_0,
    input wire logic        select_pin_1,
    input wire logic        dac_rail,
    input wire logic [2:0]  buffer_run,
    input wire logic [1:0]  active_ref,
    input wire logic        holdover,
    input wire logic [5:0]  prediv_sel,
    input wire logic        lock_status_pin
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [2:0]  wsel;   // Pending write target, 0 = none
    logic [31:0] ctrl_q; // Shadow copies of the writable registers
    logic [31:0] in_q;
    logic [31:0] pin_q;
    logic [1:0]  eff;    // Pin levels as seen, output pins read 0
    // Shadow registers, so rules can be tied to programmed values
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wsel   <= 3'h0;
            ctrl_q <= CTRL_RESET;
            in_q   <= INPUT_RESET;
            pin_q  <= PIN_RESET;
        end else begin
            wsel <= (hsel && hready && htrans[1] && hwrite
                     && haddr[7:4] == 4'h0) ? {1'b0, haddr[3:2]} + 3'h1
                                            : 3'h0;
            if (wsel == 3'h1) ctrl_q <= hwdata;
            if (wsel == 3'h2) in_q <= hwdata;
            if (wsel == 3'h3) pin_q <= hwdata;
        end
    end
    // Direction gate on each select pin
    always_comb eff = {select_pin_1 & pin_q[1], select_pin_0 & pin_q[0]};
    // Pin mode, holdover off, pins and setup quiet long enough to sync
    sequence s_pins_settled;
        (ctrl_q[2:0] == MODE_PIN && !ctrl_q[4] && !ctrl_q[5]
         && $stable(eff) && $stable(ctrl_q) && $stable(pin_q))[*5];
    endsequence
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_manual_ref: assert property ((ctrl_q[2:0] < 3'h3
        && $stable(ctrl_q))[*3] |-> active_ref == ctrl_q[1:0])
        else $error("manual mode reference wrong");
    a_manual_buf: assert property ((ctrl_q[2:0] < 3'h3
        && $stable(ctrl_q))[*3] |-> buffer_run[ctrl_q[1:0]])
        else $error("selected buffer not running");
    a_pin_decode: assert property (s_pins_settled
        |-> (eff == 2'h3 ? holdover : active_ref == eff && !holdover))
        else $error("pin select decode wrong");
    a_prediv_map: assert property ($stable(in_q)[*2]
        |-> prediv_sel == in_q[9:4])
        else $error("pre-divider codes wrong");
    a_force_hold: assert property (ctrl_q[5][*3] |-> holdover)
        else $error("force did not hold");
    a_hold_exit: assert property (($stable(ctrl_q) && !ctrl_q[5]
        && !ctrl_q[4] && ctrl_q[2:0] != MODE_PIN)[*4] |-> !holdover)
        else $error("holdover stays with holdover off");
    a_rail_route: assert property ((ctrl_q[9:8] == LD_RAIL
        && $stable(dac_rail) && $stable(ctrl_q))[*3]
        |-> lock_status_pin == dac_rail)
        else $error("rail not routed to lock pin");
endmodule
bind ref_switch ref_switch_monitor u_mon (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .select_pin_0(select_pin_0), .select_pin_1(select_pin_1),
    .dac_rail(dac_rail), .buffer_run(buffer_run), .active_ref(active_ref),
    .holdover(holdover), .prediv_sel(prediv_sel),
    .lock_status_pin(lock_status_pin));
`default_nettype wire

//--- bench/ref_partner.sv
// Far side: select pin drivers and first loop lock detect
`timescale 1ns/1ps
`default_nettype none
module ref_partner (
    input  wire logic       hclk,
    input  wire logic [1:0] pin_req,
    input  wire logic       lock_req,
    output var logic        select_pin_0 = 1'b0,
    output var logic        select_pin_1 = 1'b0,
    output var logic        loop1_lock_detect = 1'b1
);
    // Levels move just after an edge, never on it
    always @(posedge hclk) begin
        {select_pin_1, select_pin_0} <= pin_req;
        loop1_lock_detect <= lock_req;
    end
endmodule
`default_nettype wire

//--- bench/ref_switch_tb.sv
// Testbench for reference input switching
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module ref_switch_tb;
    import ref_switch_pkg::*;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [1:0]  htrans = 2'h0, pin_req = 2'h0;
    logic        lock_req = 1'b1, freq_tol = 1'b0, rail = 1'b0;
    wire logic [31:0] hrdata;
    wire logic hreadyout, hresp, sp0, sp1, lock1, hold, lsp;
    wire logic [2:0] brun;
    wire logic [1:0] aref;
    wire logic [5:0] pdiv;
    int n_errors = 0, compares = 0;
    // 50 ns clock
    initial forever #25 hclk = ~hclk;
    ref_partner u_far (.hclk(hclk), .pin_req(pin_req), .lock_req(lock_req),
        .select_pin_0(sp0), .select_pin_1(sp1), .loop1_lock_detect(lock1));
    ref_switch DUT (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .select_pin_0(sp0),
        .select_pin_1(sp1), .loop1_lock_detect(lock1),
        .loop2_lock_detect(lock1), .dac_rail(rail),
        .freq_in_tolerance(freq_tol), .buffer_run(brun), .active_ref(aref),
        .holdover(hold), .prediv_sel(pdiv), .lock_status_pin(lsp));
    // One single AHB-Lite transfer, waits on the slave's ready
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1; htrans <= HTRANS_NONSEQ; haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask
    task automatic chkr(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        ahb(1'b0, a, 32'h0, x);
        `CHK(x, e)
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // Single exit point for the run
    task automatic report_and_stop();
        $display("errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Watchdog, far beyond the 171 cycles the tests need
    initial begin
        wt(20000);
        n_errors++;
        report_and_stop();
    end
    initial begin
        wt(8);
        hresetn <= 1'b1;
        wt(1);
        `CHK(aref, 2'h0)
        `CHK(brun, 3'h7)
        chkr(INPUT_OFFSET, INPUT_RESET);
        chkr(PIN_OFFSET, PIN_RESET);
        wr(8'h10, 32'hFFFF_FFFF);
        chkr(8'h10, 32'h0);
        // Manual modes with every enable off
        wr(INPUT_OFFSET, 32'h0000_0390);
        wt(2);
        `CHK(pdiv, 6'h39)
        for (int m = 0; m < 3; m++) begin
            wr(CTRL_OFFSET, 32'(m));
            wt(4);
            `CHK(aref, 2'(m))
            `CHK(brun[m], 1'b1)
        end
        wr(CTRL_OFFSET, 32'h0);
        rail <= 1'b1;
        wt(4);
        `CHK(lsp, 1'b1)
        wr(CTRL_OFFSET, {22'h0, LD_HOLD, 8'h20});
        rail <= 1'b0;
        wt(4);
        `CHK(hold, 1'b1)
        `CHK(lsp, 1'b1)
        // Pin mode, host disables lock-loss detect, enables all inputs
        wr(INPUT_OFFSET, 32'h7);
        wr(PIN_OFFSET, 32'h3);
        wr(CTRL_OFFSET, 32'h43);
        for (int p = 0; p < 4; p++) begin
            pin_req <= 2'(p);
            wt(6);
            if (p == 3) `CHK(hold, 1'b1)
            else `CHK(aref, 2'(p))
        end
        // Output pins read as zero
        wr(PIN_OFFSET, 32'h0);
        wt(6);
        `CHK(aref, 2'h0)
        `CHK(hold, 1'b0)
        wr(PIN_OFFSET, 32'h3);
        pin_req <= 2'h0;
        wt(6);
        // Pin switch with holdover: hold, then finish on tolerance
        wr(CTRL_OFFSET, 32'h53);
        pin_req <= 2'h2;
        wt(6);
        `CHK(hold, 1'b1)
        `CHK(aref, 2'h0)
        freq_tol <= 1'b1;
        wt(6);
        `CHK(hold, 1'b0)
        `CHK(aref, 2'h2)
        freq_tol <= 1'b0;
        // Manual lock loss with holdover on
        wr(CTRL_OFFSET, 32'h11);
        wt(4);
        lock_req <= 1'b0;
        wt(6);
        `CHK(hold, 1'b1)
        chkr(STATUS_OFFSET, 32'h9);
        wr(CTRL_OFFSET, 32'h01);
        wt(4);
        `CHK(hold, 1'b0)
        lock_req <= 1'b1;
        // Automatic mode over inputs 0 and 2, host locks on 0 first
        wr(INPUT_OFFSET, 32'h5);
        wr(CTRL_OFFSET, 32'h0);
        wt(6);
        wr(CTRL_OFFSET, {29'h0, MODE_AUTO});
        wt(4);
        `CHK(aref, 2'h0)
        lock_req <= 1'b0;
        wt(6);
        `CHK(aref, 2'h2)
        wt(6);
        `CHK(aref, 2'h2)
        lock_req <= 1'b1;
        wt(6);
        lock_req <= 1'b0;
        wt(6);
        `CHK(aref, 2'h0)
        report_and_stop();
    end
endmodule
`default_nettype wire
